// ### rtl/acr_ctrl.v
// Purpose: Command decoder, register file and status of a serial
//   delta-sigma converter.
// Assumes: Modulator and filter report on core_clk with one-cycle pulses.
// Notes: Serial pins and GPIO pins are sampled through two flip-flops.
`include "acr_map.vh"
module acr_ctrl (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Serial port pins
  input wire cs_n_pin,
  input wire sclk_pin,
  input wire din_pin,
  output reg rdy_dout,
  output reg rdy_dout_oe,
  // GPIO pins
  input wire [3:0] gpio_in,
  output wire [3:0] gpio_out,
  output wire [3:0] gpio_oe,
  // Modulator and filter results
  input wire mod_done,
  input wire [23:0] mod_result,
  input wire [23:0] mod_gain,
  input wire mod_clip_hi,
  input wire mod_clip_lo,
  input wire mod_gain_sat,
  // Modulator control
  output reg conv_start,
  output reg [1:0] cal_mode,
  output reg [2:0] conv_rate,
  output reg powered_down,
  output wire modulator_busy,
  // Converter setup
  output wire mains_50hz_sel,
  output wire unipolar_sel,
  output wire ext_clock_sel,
  output wire ref_buffer_en,
  output wire input_buffer_en,
  output wire offset_binary_sel,
  output wire one_shot_mode,
  // Correction setup
  output wire [2:0] digital_gain,
  output wire skip_system_gain,
  output wire skip_system_offset,
  output wire skip_self_gain,
  output wire skip_self_offset
);
  localparam [2:0] ST_CMD = 3'b001;
  localparam [2:0] ST_WR = 3'b010;
  localparam [2:0] ST_RD = 3'b100;
  // Registers
  reg [7:0] status_flags;
  reg [7:0] converter_setup;
  reg [7:0] gpio_setup;
  reg [7:0] gain_and_correction_setup;
  reg [23:0] conversion_result;
  reg [23:0] system_offset_coeff;
  reg [23:0] system_gain_coeff;
  reg [23:0] self_offset_coeff;
  reg [23:0] self_gain_coeff;

  // Serial engine
  reg [2:0] state;
  reg [4:0] bit_cnt;
  reg [4:0] xfer_width;
  reg [3:0] reg_select;
  reg [23:0] shift_in;
  reg [23:0] shift_out;
  reg action_req;
  reg [7:0] action_byte;
  reg wr_req;
  reg [23:0] wr_data;
  reg result_read_done;
  reg result_read_active;

  // Conversion tracking
  reg result_was_read;
  reg continuous_run;
  reg [1:0] discard_cnt;
  reg update_mark;
  reg [23:0] read_value;

  wire cs_n_sync;
  wire sclk_sync;
  wire din_sync;
  wire sclk_rise;
  wire sclk_fall;
  wire [3:0] gpio_sync;
  wire [7:0] next_cmd;
  wire [7:0] gpio_readback;
  function [4:0] reg_width;
    input [3:0] sel;
    begin
      if (sel >= `ACR_REG_RESULT) begin
        reg_width = `ACR_WIDTH_WORD;
      end else begin
        reg_width = `ACR_WIDTH_BYTE;
      end
    end
  endfunction

  acr_sync #(.WIDTH(3), .INIT(3'b100)) u_pin_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({cs_n_pin, sclk_pin, din_pin}),
    .sync_out({cs_n_sync, sclk_sync, din_sync})
  );

  acr_sync #(.WIDTH(4), .INIT(4'h0)) u_gpio_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(gpio_in),
    .sync_out(gpio_sync)
  );

  acr_sclk_edge u_edge (
    .core_clk(core_clk),
    .reset(reset),
    .sclk_sync(sclk_sync),
    .cs_n_sync(cs_n_sync),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall)
  );

  assign next_cmd = {shift_in[6:0], din_sync};
  // Inputs show the pin level, outputs their own value bit
  assign gpio_readback = {gpio_setup[7:4],
    (gpio_setup[7:4] & gpio_setup[3:0]) |
    (~gpio_setup[7:4] & gpio_sync)};
  assign gpio_out = gpio_setup[3:0];
  assign gpio_oe = gpio_setup[7:4];

  assign modulator_busy = status_flags[`ACR_ST_BUSY];
  assign mains_50hz_sel = converter_setup[7];
  assign unipolar_sel = converter_setup[6];
  assign ext_clock_sel = converter_setup[5];
  assign ref_buffer_en = converter_setup[4];
  assign input_buffer_en = converter_setup[3];
  assign offset_binary_sel = converter_setup[2];
  assign one_shot_mode = converter_setup[1];
  assign digital_gain = gain_and_correction_setup[7:5];
  assign skip_system_gain = gain_and_correction_setup[4];
  assign skip_system_offset = gain_and_correction_setup[3];
  assign skip_self_gain = gain_and_correction_setup[2];
  assign skip_self_offset = gain_and_correction_setup[1];

  // Byte registers sit in the low bits; left-justify for shifting out
  always @* begin
    read_value = 24'h000000;
    case (next_cmd[4:1])
      `ACR_REG_STATUS: read_value = {status_flags, 16'h0000};
      `ACR_REG_SETUP: read_value = {converter_setup, 16'h0000};
      `ACR_REG_GPIO: read_value = {gpio_readback, 16'h0000};
      `ACR_REG_GAINCORR: read_value = {gain_and_correction_setup, 16'h0000};
      `ACR_REG_RESULT: read_value = conversion_result;
      `ACR_REG_SYS_OFS: read_value = system_offset_coeff;
      `ACR_REG_SYS_GAIN: read_value = system_gain_coeff;
      `ACR_REG_SELF_OFS: read_value = self_offset_coeff;
      `ACR_REG_SELF_GAIN: read_value = self_gain_coeff;
      default: read_value = 24'h000000;
    endcase
  end

  // Serial framing: command byte, then optional data phase
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= ST_CMD;
      bit_cnt <= 5'd0;
      xfer_width <= `ACR_WIDTH_BYTE;
      reg_select <= 4'h0;
      shift_in <= 24'h000000;
      shift_out <= 24'h000000;
      action_req <= 1'b0;
      action_byte <= 8'h00;
      wr_req <= 1'b0;
      wr_data <= 24'h000000;
      result_read_done <= 1'b0;
      result_read_active <= 1'b0;
      rdy_dout <= 1'b1;
      rdy_dout_oe <= 1'b0;
    end else begin
      action_req <= 1'b0;
      wr_req <= 1'b0;
      result_read_done <= 1'b0;
      rdy_dout_oe <= ~cs_n_sync;
      if (cs_n_sync) begin
        state <= ST_CMD;
        bit_cnt <= 5'd0;
        result_read_active <= 1'b0;
      end else begin
        case (state)
          ST_CMD: begin
            // Leading zeros are skipped until the start bit arrives
            if (sclk_rise && (bit_cnt != 5'd0 || din_sync)) begin
              shift_in <= {16'h0000, next_cmd};
              bit_cnt <= bit_cnt + 5'd1;
              if (bit_cnt == 5'd7) begin
                bit_cnt <= 5'd0;
                reg_select <= next_cmd[4:1];
                xfer_width <= reg_width(next_cmd[4:1]);
                if (!next_cmd[`ACR_CMD_MODE]) begin
                  action_req <= 1'b1;
                  action_byte <= next_cmd;
                end else if (next_cmd[5]) begin
                  state <= ST_CMD;
                end else if (next_cmd[0]) begin
                  state <= ST_RD;
                  shift_out <= read_value;
                  result_read_active <= (next_cmd[4:1] == `ACR_REG_RESULT);
                end else begin
                  state <= ST_WR;
                end
              end
            end
          end
          ST_WR: begin
            if (sclk_rise) begin
              shift_in <= {shift_in[22:0], din_sync};
              bit_cnt <= bit_cnt + 5'd1;
              if (bit_cnt == xfer_width - 5'd1) begin
                bit_cnt <= 5'd0;
                wr_req <= 1'b1;
                wr_data <= {shift_in[22:0], din_sync};
                state <= ST_CMD;
              end
            end
          end
          ST_RD: begin
            if (sclk_fall) begin
              rdy_dout <= shift_out[23];
              shift_out <= {shift_out[22:0], 1'b0};
            end
            if (sclk_rise) begin
              bit_cnt <= bit_cnt + 5'd1;
              if (bit_cnt == xfer_width - 5'd1) begin
                bit_cnt <= 5'd0;
                result_read_done <= result_read_active;
                result_read_active <= 1'b0;
                state <= ST_CMD;
              end
            end
          end
          default: state <= ST_CMD;
        endcase
      end
      // Between transfers the line reports conversion status
      if (cs_n_sync || (state == ST_CMD && !sclk_fall)) begin
        if (!converter_setup[1]) begin
          // Low blip on each update gives the host a rising edge
          rdy_dout <= ~update_mark;
        end else begin
          rdy_dout <= ~status_flags[`ACR_ST_RDY];
        end
      end
    end
  end

  // Register writes, actions and status
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_flags <= `ACR_RST_STATUS;
      converter_setup <= `ACR_RST_SETUP;
      gpio_setup <= `ACR_RST_GPIO;
      gain_and_correction_setup <= `ACR_RST_GAINCORR;
      conversion_result <= `ACR_RST_WORD;
      system_offset_coeff <= `ACR_RST_WORD;
      system_gain_coeff <= `ACR_RST_WORD;
      self_offset_coeff <= `ACR_RST_WORD;
      self_gain_coeff <= `ACR_RST_WORD;
      conv_start <= 1'b0;
      cal_mode <= `ACR_CAL_NONE;
      conv_rate <= 3'b000;
      powered_down <= 1'b1;
      result_was_read <= 1'b0;
      continuous_run <= 1'b0;
      discard_cnt <= 2'd0;
      update_mark <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      update_mark <= 1'b0;
      if (wr_req) begin
        case (reg_select)
          `ACR_REG_SETUP:
            converter_setup <= wr_data[7:0] & `ACR_SETUP_WMASK;
          `ACR_REG_GPIO:
            gpio_setup <= wr_data[7:0];
          `ACR_REG_GAINCORR:
            gain_and_correction_setup <=
              wr_data[7:0] & `ACR_GAINCORR_WMASK;
          `ACR_REG_SYS_OFS: system_offset_coeff <= wr_data;
          `ACR_REG_SYS_GAIN: system_gain_coeff <= wr_data;
          `ACR_REG_SELF_OFS: self_offset_coeff <= wr_data;
          `ACR_REG_SELF_GAIN: begin
            // A running conversion or calibration locks this coefficient
            if (!status_flags[`ACR_ST_BUSY]) begin
              self_gain_coeff <= wr_data;
            end
          end
          // Status, result and unknown selects keep their value
          default: conversion_result <= conversion_result;
        endcase
      end
      // Read with a later conversion running clears ready at once
      if (result_read_done) begin
        if (status_flags[`ACR_ST_BUSY]) begin
          status_flags[`ACR_ST_RDY] <= 1'b0;
        end else begin
          result_was_read <= 1'b1;
        end
      end
      if (action_req) begin
        if (action_byte[`ACR_CMD_PD] &&
            action_byte[5:4] == `ACR_CAL_NONE) begin
          powered_down <= 1'b1;
          continuous_run <= 1'b0;
          status_flags[`ACR_ST_BUSY] <= 1'b0;
        end else begin
          conv_start <= 1'b1;
          powered_down <= 1'b0;
          cal_mode <= action_byte[5:4];
          // Calibrations run with a rate field of zero
          conv_rate <= (action_byte[5:4] == `ACR_CAL_NONE) ?
            action_byte[2:0] : 3'b000;
          continuous_run <= ~converter_setup[1] &&
            (action_byte[5:4] == `ACR_CAL_NONE);
          discard_cnt <= converter_setup[1] ? 2'd0 :
            `ACR_SKIP_RESULTS;
          status_flags[`ACR_ST_BUSY] <= 1'b1;
          // Only a result already read is cleared; unread keeps ready
          if (result_was_read || result_read_done) begin
            status_flags[`ACR_ST_RDY] <= 1'b0;
            result_was_read <= 1'b0;
          end
        end
      end else if (mod_done && status_flags[`ACR_ST_BUSY]) begin
        if (!continuous_run) begin
          status_flags[`ACR_ST_BUSY] <= 1'b0;
          powered_down <= 1'b1;
        end
        status_flags[6:4] <= conv_rate;
        case (cal_mode)
          `ACR_CAL_SELF: begin
            self_offset_coeff <= mod_result;
            self_gain_coeff <= mod_gain;
          end
          `ACR_CAL_SYS_OFS: begin
            system_offset_coeff <= mod_result;
          end
          `ACR_CAL_SYS_GAIN: begin
            system_gain_coeff <= mod_gain;
            status_flags[`ACR_ST_OVR] <= mod_gain_sat;
          end
          default: begin
            if (discard_cnt != 2'd0) begin
              // Filter still settling; result is not published
              discard_cnt <= discard_cnt - 2'd1;
            end else begin
              conversion_result <= mod_result;
              status_flags[`ACR_ST_CLIP_HI] <= mod_clip_hi;
              status_flags[`ACR_ST_CLIP_LO] <= mod_clip_lo;
              // Set wins over a read clearing in the same cycle
              status_flags[`ACR_ST_RDY] <= 1'b1;
              result_was_read <= 1'b0;
              update_mark <= 1'b1;
            end
          end
        endcase
      end
    end
  end
endmodule

// ### rtl/acr_map.vh
// Purpose: Offsets, reset values and field positions of the converter
//   command and register control block.
// Assumes: Included by the acr_ctrl design file only.
// Notes: Rules carried by this block, one per line.
// Function
// - Command bit 6 at 0 requests an action, at 1 a register access.
// - Calibration bits: 01 self, 10 system offset, 11 system gain cal.
// - Power-down bit stops at once, else rate code starts a conversion; code ignores it when calibration bits are nonzero.
// - Four-bit select: 0-3 are 8-bit registers, 4-8 are 24-bit.
// - Power-on values: 0x00, 0x02, 0x0f, 0x1e, and zero for 24-bit.
// - Status bit 7 flags a saturated system gain calibration.
// - Status bits 6:4 hold the rate of the held result or calibration; code also loads them on discarded results.
// - Status bit 3 set when result clipped high, else cleared.
// - Status bit 2 set when result clipped low, else cleared.
// - Status bit 1 high while conversion or calibration is running.
// - Ready bit cleared by a result read only once a new conversion runs.
// - Ready stays set if a conversion starts before the result is read.
// - Setup bit 7 picks 50 Hz rate set at 1, 60 Hz at 0.
// - Setup bit 6 picks unipolar, bit 5 picks the external clock.
// - Setup bits 4 and 3 enable reference and signal buffers.
// - Setup bit 2 picks offset binary for bipolar results.
// - Setup bit 1: one-shot then power down; else continuous, 3 discarded.
// - Continuous mode marks each result with a 0-to-1 step on data out.
// - GPIO direction bits 7:4; inputs read pins, outputs drive value bits.
// - Gain bits 7:5 give a digital gain of 1 to 128.
// - Gain setup bits 4:1 drop each correction coefficient when 1.
// - Access byte: bit 6 one, bit 5 zero, select 4:1, write/read bit 0.
// - Input sampled on rising clock, output shifted on falling, MSB first.
// - A result read shifts 24 bits out MSB first.
`ifndef ACR_MAP_VH
`define ACR_MAP_VH

`define ACR_REG_STATUS 4'h0
`define ACR_REG_SETUP 4'h1
`define ACR_REG_GPIO 4'h2
`define ACR_REG_GAINCORR 4'h3
`define ACR_REG_RESULT 4'h4
`define ACR_REG_SYS_OFS 4'h5
`define ACR_REG_SYS_GAIN 4'h6
`define ACR_REG_SELF_OFS 4'h7
`define ACR_REG_SELF_GAIN 4'h8

`define ACR_RST_STATUS 8'h00
`define ACR_RST_SETUP 8'h02
`define ACR_RST_GPIO 8'h0f
`define ACR_RST_GAINCORR 8'h1e
`define ACR_RST_WORD 24'h000000
`define ACR_SETUP_WMASK 8'hfe
`define ACR_GAINCORR_WMASK 8'hfe

`define ACR_CMD_START 7
`define ACR_CMD_MODE 6
`define ACR_CMD_PD 3
`define ACR_CAL_NONE 2'b00
`define ACR_CAL_SELF 2'b01
`define ACR_CAL_SYS_OFS 2'b10
`define ACR_CAL_SYS_GAIN 2'b11

`define ACR_ST_OVR 7
`define ACR_ST_CLIP_HI 3
`define ACR_ST_CLIP_LO 2
`define ACR_ST_BUSY 1
`define ACR_ST_RDY 0

`define ACR_WIDTH_BYTE 5'd8
`define ACR_WIDTH_WORD 5'd24
`define ACR_SKIP_RESULTS 2'd3

`endif

// ### rtl/acr_sync.v
// Purpose: Two-stage synchroniser for pins from outside core_clk.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage may be read.
module acr_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta <= INIT;
      sync_out <= INIT;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ### rtl/acr_sclk_edge.v
// Purpose: Finds serial clock edges inside a selected frame.
// Assumes: Inputs are already synchronised to core_clk.
// Notes: Edges are masked while chip select is high.
module acr_sclk_edge (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Synchronised pins
  input wire sclk_sync,
  input wire cs_n_sync,
  // Edge pulses
  output reg sclk_rise,
  output reg sclk_fall
);
  reg sclk_prev;

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sclk_prev <= 1'b0;
      sclk_rise <= 1'b0;
      sclk_fall <= 1'b0;
    end else begin
      sclk_prev <= sclk_sync;
      // Deselected device ignores the clock entirely
      sclk_rise <= ~cs_n_sync & sclk_sync & ~sclk_prev;
      sclk_fall <= ~cs_n_sync & ~sclk_sync & sclk_prev;
    end
  end
endmodule

// ### testbench/acr_ctrl_sva.sv
// Purpose: Port-level checks for acr_ctrl.
// Assumes: Modulator pulses come from the bench stand-in.
// Notes: Held outputs are checked a cycle late to allow registering.
module acr_ctrl_sva (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Observed ports
  input wire cs_n_pin,
  input wire rdy_dout_oe,
  input wire mod_done,
  input wire conv_start,
  input wire [1:0] cal_mode,
  input wire [2:0] conv_rate,
  input wire powered_down,
  input wire modulator_busy,
  input wire one_shot_mode,
  input wire [2:0] digital_gain,
  input wire [3:0] gpio_oe,
  input wire [3:0] gpio_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire done_ok = mod_done && modulator_busy && !conv_start;
  AST_RESET_STATE: assert property ($fell(reset) |-> powered_down &&
    one_shot_mode && digital_gain == 3'h0 && gpio_oe == 4'h0 &&
    gpio_out == 4'hf) else $error("bad state after reset");
  AST_OE_OFF: assert property (cs_n_pin [*4] |-> !rdy_dout_oe)
    else $error("output enabled while deselected");
  AST_OE_ON: assert property (!cs_n_pin [*4] |-> rdy_dout_oe)
    else $error("output not enabled while selected");
  AST_START_BUSY: assert property (conv_start |-> modulator_busy)
    else $error("start without busy");
  AST_START_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  AST_START_AWAKE: assert property (conv_start |=> !powered_down)
    else $error("powered down after start");
  AST_CAL_RATE: assert property (conv_start |=>
    (cal_mode == 2'b00 || conv_rate == 3'h0))
    else $error("calibration with nonzero rate");
  AST_ONE_SHOT_END: assert property (done_ok && one_shot_mode |=>
    ##[0:1] (powered_down && !modulator_busy))
    else $error("one-shot did not power down");
  AST_CAL_END: assert property (done_ok && cal_mode != 2'b00 |=>
    ##[0:1] (powered_down && !modulator_busy))
    else $error("calibration did not end");
  AST_CONT_RUN: assert property (done_ok && !one_shot_mode &&
    cal_mode == 2'b00 |=> !powered_down [*2])
    else $error("continuous mode stopped");
endmodule

// ### testbench/acr_host.sv
// Purpose: Serial host model driving the four-wire port.
// Assumes: Link clock of 160 ns; frames start 7 ns after a core_clk edge.
// Notes: Serial clock rests low outside frames.
module acr_host (
  // Clock
  input wire core_clk,
  // Serial pins
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic din_pin,
  input wire rdy_dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] rdata;
  event got;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    din_pin = 1'b1;
  end
  // Holding select low lets the bench watch result marks
  task select(input logic on);
    @(posedge core_clk);
    #7 cs_n_pin = !on;
  endtask
  task xfer(input logic [31:0] tx, input int n, input logic rd);
    logic [31:0] rx;
    rx = '0;
    // Fixed phase keeps pin edges and our sampling clear of core_clk edges
    @(posedge core_clk);
    #7 cs_n_pin = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      din_pin = tx[i];
      #80 sclk_pin = 1'b1;
      rx = {rx[30:0], rdy_dout};
      #80 sclk_pin = 1'b0;
    end
    // Released data line must not keep the last bit
    din_pin = !din_pin;
    #160 cs_n_pin = 1'b1;
    #200;
    rdata = rx[23:0];
    if (rd)
      -> got;
  endtask
endmodule

// ### testbench/acr_ctrl_tb.sv
// Purpose: Self-checking bench for acr_ctrl.
// Assumes: Host model owns the serial pins.
// Notes: Read results are compared by a watcher against a queue.
module acr_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] gpio_in = 4'hf;
  logic mod_done = 1'b0;
  logic mod_clip_hi = 1'b0;
  logic mod_clip_lo = 1'b0;
  logic mod_gain_sat = 1'b0;
  logic [23:0] mod_result = '0;
  logic [23:0] mod_gain = '0;
  logic [31:0] seed = 32'd96506;
  logic [47:0] expq[$];
  int mismatches = 0;
  int samples_checked = 0;
  int mdelay = 40;
  int mcnt = 0;
  int ndone = 0;
  int nrise = 0;
  wire cs_n_pin, sclk_pin, din_pin, rdy_dout, rdy_dout_oe;
  wire conv_start, powered_down, modulator_busy;
  wire [3:0] gpio_out, gpio_oe, skip_bits;
  wire [1:0] cal_mode;
  wire [2:0] conv_rate, digital_gain;
  wire [6:0] cfg_bits;
  acr_ctrl acr_ctrl_i (.core_clk(core_clk), .reset(reset),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .din_pin(din_pin),
    .rdy_dout(rdy_dout), .rdy_dout_oe(rdy_dout_oe), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .mod_done(mod_done),
    .mod_result(mod_result), .mod_gain(mod_gain),
    .mod_clip_hi(mod_clip_hi), .mod_clip_lo(mod_clip_lo),
    .mod_gain_sat(mod_gain_sat), .conv_start(conv_start),
    .cal_mode(cal_mode), .conv_rate(conv_rate),
    .powered_down(powered_down), .modulator_busy(modulator_busy),
    .mains_50hz_sel(cfg_bits[6]), .unipolar_sel(cfg_bits[5]),
    .ext_clock_sel(cfg_bits[4]), .ref_buffer_en(cfg_bits[3]),
    .input_buffer_en(cfg_bits[2]), .offset_binary_sel(cfg_bits[1]),
    .one_shot_mode(cfg_bits[0]), .digital_gain(digital_gain),
    .skip_system_gain(skip_bits[3]), .skip_system_offset(skip_bits[2]),
    .skip_self_gain(skip_bits[1]), .skip_self_offset(skip_bits[0]));
  acr_host acr_host_i (.core_clk(core_clk), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .din_pin(din_pin), .rdy_dout(rdy_dout));
  always #10 core_clk = ~core_clk;
  // Modulator stand-in: one result every mdelay+1 cycles while busy
  always @(posedge core_clk) begin
    mcnt <= (modulator_busy && mcnt != mdelay) ? mcnt + 1 : 0;
    mod_done <= #1 modulator_busy && mcnt == mdelay;
    if (mod_done)
      ndone <= ndone + 1;
    if (rdy_dout_oe && $past(rdy_dout_oe) && $rose(rdy_dout))
      nrise <= nrise + 1;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task rnd;
    seed = next_rand(seed);
  endtask
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] sel, input int w, input logic [23:0] d);
    acr_host_i.xfer(({24'h0, 3'b110, sel, 1'b0} << w) | d, 8 + w, 1'b0);
  endtask
  task rd(input logic [3:0] sel, input int w, input logic [23:0] m,
      input logic [23:0] e);
    expq.push_back({m, e & m});
    acr_host_i.xfer({24'h0, 3'b110, sel, 1'b1} << w, 8 + w, 1'b1);
  endtask
  task act(input logic [7:0] cmd);
    acr_host_i.xfer({24'h0, cmd}, 8, 1'b0);
  endtask
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  task wait_idle;
    for (int n = 0; modulator_busy !== 1'b0; n++) begin
      if (n == 3000) begin
        mismatches++;
        stop_test;
      end
      tick;
    end
  endtask
  always @(acr_host_i.got) begin
    chk(acr_host_i.rdata & expq[0][47:24], expq[0][23:0]);
    void'(expq.pop_front());
  end
  initial begin
    #1_600_000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (20) tick;
    reset = 1'b0;
    repeat (5) tick;
    for (int s = 0; s < 11; s++)
      rd(4'(s < 9 ? s : s + 4), s < 4 ? 8 : 24,
        s < 4 ? 24'hff : 24'hffffff,
        s == 1 ? 24'h02 : s == 2 ? 24'h0f : s == 3 ? 24'h1e : 24'h0);
    rnd;
    wr(4'h1, 8, {seed[7:2], 2'b11});
    chk({cfg_bits, 1'b0}, {seed[7:2], 2'b10});
    rd(4'h1, 8, 24'hff, {seed[7:2], 2'b10});
    rnd;
    wr(4'h3, 8, {seed[7:1], 1'b1});
    chk({digital_gain, skip_bits, 1'b0}, {seed[7:1], 1'b0});
    rd(4'h3, 8, 24'hff, {seed[7:1], 1'b0});
    rnd;
    tick;
    gpio_in = seed[11:8];
    wr(4'h2, 8, seed[7:0]);
    chk({gpio_oe, gpio_out}, seed[7:0]);
    rd(4'h2, 8, 24'hff, {seed[7:4],
      seed[3:0] & seed[7:4] | seed[11:8] & ~seed[7:4]});
    wr(4'h0, 8, 8'hff);
    wr(4'h4, 24, 24'hffffff);
    rd(4'h0, 8, 24'hff, 24'h0);
    rd(4'h4, 24, 24'hffffff, 24'h0);
    for (int s = 5; s < 9; s++) begin
      rnd;
      wr(4'(s), 24, seed[23:0]);
      rd(4'(s), 24, 24'hffffff, seed[23:0]);
    end
    for (int r = 7; r >= 0; r--) begin
      rnd;
      tick;
      mod_result = seed[23:0];
      mod_clip_hi = r[0];
      mod_clip_lo = r[1] & !r[0];
      act({5'b10000, r[2:0]});
      chk({cal_mode, conv_rate}, 24'(r));
      wait_idle;
      chk(powered_down, 1'b1);
      rd(4'h0, 8, 24'hff,
        {1'b0, r[2:0], r[0], r[1] & !r[0], 2'b01});
      rd(4'h4, 24, 24'hffffff, seed[23:0]);
    end
    for (int c = 1; c < 4; c++) begin
      rnd;
      tick;
      mod_result = seed[23:0];
      mod_gain = seed[31:8];
      mod_clip_hi = 1'b0;
      mod_clip_lo = 1'b0;
      mod_gain_sat = c == 3;
      act({2'b10, c[1:0], 4'h0});
      chk(cal_mode, 24'(c));
      wait_idle;
      rd(4'h0, 8, 24'hf2, {c == 3, 7'h0});
      rd(c == 1 ? 4'h8 : c == 2 ? 4'h5 : 4'h6, 24, 24'hffffff,
        c == 2 ? seed[23:0] : seed[31:8]);
      if (c == 1)
        rd(4'h7, 24, 24'hffffff, seed[23:0]);
    end
    // Ready survives a start before the read, then clears after a busy read
    tick;
    mod_gain_sat = 1'b0;
    act(8'h83);
    wait_idle;
    mdelay = 600;
    act(8'h85);
    rd(4'h0, 8, 24'h7f, 24'h33);
    rd(4'h4, 24, 24'hffffff, mod_result);
    rd(4'h0, 8, 24'h7f, 24'h32);
    wait_idle;
    mdelay = 40;
    wr(4'h1, 8, 8'h00);
    act(8'h84);
    ndone = 0;
    nrise = 0;
    acr_host_i.select(1'b1);
    for (int n = 0; n < 3000 && ndone < 8; n++)
      tick;
    repeat (8) tick;
    chk(24'(nrise), 24'd5);
    chk(powered_down, 1'b0);
    acr_host_i.select(1'b0);
    // Keep the next result away from the power-down byte
    mdelay = 600;
    act(8'h88);
    chk(powered_down, 1'b1);
    stop_test;
  end
endmodule
bind acr_ctrl acr_ctrl_sva acr_ctrl_sva_i (.core_clk(core_clk),
  .reset(reset), .cs_n_pin(cs_n_pin), .rdy_dout_oe(rdy_dout_oe),
  .mod_done(mod_done), .conv_start(conv_start), .cal_mode(cal_mode),
  .conv_rate(conv_rate), .powered_down(powered_down),
  .modulator_busy(modulator_busy), .one_shot_mode(one_shot_mode),
  .digital_gain(digital_gain), .gpio_oe(gpio_oe), .gpio_out(gpio_out));
